// file: disk_status_pkg.sv
/*
 * shared constants and types for the disk channel drive-status readback:
 * function codes, status request parameters, response field positions,
 * completion delay and the request and drive-status carriers.
 * assumes a 100 MHz clock and 16-bit function parameters.
 */
`default_nettype none

package disk_status_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned STATUS_DELAY_NS = 2000;                    // completion delay of a status request
	localparam int unsigned STATUS_CYC      = (STATUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W           = 8;

	// ------------------------------------------------------------
	// function codes and status request parameters
	// ------------------------------------------------------------
	localparam logic [3:0]  FN_STATUS      = 4'h1;
	localparam logic [3:0]  FN_READ        = 4'h2;
	localparam logic [3:0]  FN_SEL_HEAD    = 4'h4;
	localparam logic [3:0]  FN_SEL_CYL     = 4'h5;
	localparam logic [3:0]  FN_SEL_OFFSET  = 4'h6;
	localparam logic [3:0]  FN_READ_STATUS = 4'h9;                     // function 11 octal
	localparam logic [15:0] PRM_READ_CYL   = 16'h0E00;                 // 007000 octal
	localparam logic [15:0] PRM_READ_HEAD  = 16'h0E01;
	localparam logic [15:0] PRM_READ_DIFF  = 16'h0E02;
	localparam logic [15:0] PRM_READ_ILK   = 16'h0E03;

	// ------------------------------------------------------------
	// response word layout
	// ------------------------------------------------------------
	localparam logic [15:0] STATUS_RESET   = 16'h0000;
	localparam int unsigned CYL_W          = 10;
	localparam int unsigned HEAD_W         = 4;
	localparam int unsigned HEAD_RES_BIT   = 5;
	localparam int unsigned HEAD_CAP_BIT   = 6;
	localparam int unsigned OFS_W          = 5;
	localparam int unsigned OFS_DIR_BIT    = 5;
	localparam int unsigned ILK_W          = 8;
	localparam int unsigned ILK_ZERO_BIT   = 5;
	localparam int unsigned LOST_FN_BIT    = 14;                       // position in error-flag status

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SEL_CYL, SEL_HEAD, SEL_DIFF, SEL_ILK} stat_sel_t;
	typedef enum logic [1:0] {POS_NONE, POS_OFFSET, POS_CYL} last_pos_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  code;
		logic [15:0] acc;
	} fn_req_t;

	typedef struct packed {
		logic [9:0]  cyl_sel;
		logic [3:0]  head_grp;
		logic        reserved;
		logic        cap_600;
		logic [4:0]  offset_num;
		logic        offset_inward;
		logic [9:0]  cyl_to_go;
		logic [7:0]  interlock;
		logic        head_active;
		logic        seek_done;
	} drive_stat_t;

endpackage : disk_status_pkg

`default_nettype wire

// file: status_word_format.sv
/*
 * builds the 16-bit status response word for one drive-status request
 * from the live drive status lines.
 * assumes the drive lines are stable while the word is loaded.
 */
`timescale 1ns/1ns
`default_nettype none

module status_word_format (
	// request selection
	input  wire disk_status_pkg::stat_sel_t   sel,
	input  wire disk_status_pkg::last_pos_t   last_pos,
	// drive lines
	input  wire disk_status_pkg::drive_stat_t drv,
	// formatted word
	output logic [15:0]                       word
);
	logic [9:0] ofs_comp;

	// ------------------------------------------------------------
	// ones complement helper, shared by margin and difference
	// ------------------------------------------------------------
	function automatic logic [9:0] ones_comp(input logic [9:0] v);
		ones_comp = ~v;
	endfunction : ones_comp

	// complemented offset number through the shared helper
	assign ofs_comp = ones_comp({5'h00, drv.offset_num});

	// ------------------------------------------------------------
	// response selection, unassigned bits stay zero
	// ------------------------------------------------------------
	always_comb begin
		word = disk_status_pkg::STATUS_RESET;
		unique case (sel)
			disk_status_pkg::SEL_CYL: begin
				word[disk_status_pkg::CYL_W-1:0] = drv.cyl_sel;
			end
			disk_status_pkg::SEL_HEAD: begin
				if (drv.reserved) begin
					word[disk_status_pkg::HEAD_W-1:0]  = drv.head_grp;
					word[disk_status_pkg::HEAD_RES_BIT] = 1'b1;
					word[disk_status_pkg::HEAD_CAP_BIT] = drv.cap_600;
				end
			end
			disk_status_pkg::SEL_DIFF: begin
				if (last_pos == disk_status_pkg::POS_OFFSET) begin
					word[disk_status_pkg::OFS_W-1:0] = ofs_comp[disk_status_pkg::OFS_W-1:0];
					word[disk_status_pkg::OFS_DIR_BIT] = drv.offset_inward;
				end else if (last_pos == disk_status_pkg::POS_CYL) begin
					word[disk_status_pkg::CYL_W-1:0] = ones_comp(drv.cyl_to_go);
				end
			end
			disk_status_pkg::SEL_ILK: begin
				word[disk_status_pkg::ILK_W-1:0]     = drv.interlock;
				word[disk_status_pkg::ILK_ZERO_BIT] = 1'b0;
			end
		endcase
	end

endmodule : status_word_format

`default_nettype wire

// file: disk_status_ctrl.sv
/*
 * function interpreter of the disk channel for the drive-status requests:
 * busy/done handshake, response loading, read-status transfer, stacking
 * of one function behind a head-group select and lost-function tracking.
 * assumes function strobes are one-cycle pulses synchronous to clock and
 * that the drive pulses head_active and seek_done for one cycle.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - status request: busy up, later done, load
// - cylinder number in low ten bits
// - response word held until next load
// - reserved: head group low bits, bit5
// - bit6 marks 600 megabyte drive
// - head response spans octal 40 to 51
// - not reserved: head response all zero
// - after offset select: complemented offset, five bits
// - bit5 set when offset toward centre
// - after cylinder select: complemented cylinders to go
// - eight interlock flags in low bits
// - fixed meaning for each interlock bit
// - interlock bit5 always zero
// - one function stacks behind head select
// - status displaces stacked read, flags lost
// - status during seek completes, separate done
// - read-status moves response to accumulator
// - early function sets lost-function flag
module disk_status_ctrl (
	// clock, reset, enable
	input  wire logic                         clock,
	input  wire logic                         sys_rst,
	input  wire logic                         ce,
	// function requests from the processor
	input  wire disk_status_pkg::fn_req_t     fn,
	input  wire logic                         lost_fn_clear,
	// disk drive unit status
	input  wire disk_status_pkg::drive_stat_t drv,
	// channel flags and response
	output logic                              busy,
	output logic                              done,
	output logic                              done_evt,
	output logic [15:0]                       status_word,
	output logic                              lost_function,
	// accumulator transfer
	output logic [15:0]                       acc_out,
	output logic                              acc_valid,
	// read path launch
	output logic                              read_start,
	output logic [15:0]                       read_sector,
	// commands forwarded to the disk drive unit
	output logic                              drv_cmd_valid,
	output logic [3:0]                        drv_cmd_code,
	output logic [15:0]                       drv_cmd_arg
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic {PH_IDLE, PH_WAIT} phase_t;

	typedef struct packed {
		phase_t                     phase;
		logic [disk_status_pkg::CNT_W-1:0] cnt;
		disk_status_pkg::stat_sel_t sel;
		disk_status_pkg::last_pos_t last_pos;
		logic                       busy;
		logic                       done;
		logic                       done_evt;
		logic [15:0]                status_word;
		logic [15:0]                acc_out;
		logic                       acc_valid;
		logic                       head_pend;
		logic                       cyl_pend;
		logic                       stack_valid;
		logic [15:0]                stack_arg;
		logic                       read_start;
		logic [15:0]                read_sector;
		logic                       lost_fn;
		logic                       cmd_valid;
		logic [3:0]                 cmd_code;
		logic [15:0]                cmd_arg;
	} state_t;

	state_t      st_ff;
	state_t      nxt_st;
	logic [15:0] fmt_word;
	logic        is_status;
	logic        acc_stat;
	logic        load_now;

	// ------------------------------------------------------------
	// response formatter
	// ------------------------------------------------------------
	status_word_format u_fmt (
		.sel      (st_ff.sel),
		.last_pos (st_ff.last_pos),
		.drv      (drv),
		.word     (fmt_word)
	);

	// request decode and completion strobe
	assign is_status = fn.valid && fn.code == disk_status_pkg::FN_STATUS &&
		(fn.acc == disk_status_pkg::PRM_READ_CYL || fn.acc == disk_status_pkg::PRM_READ_HEAD ||
		 fn.acc == disk_status_pkg::PRM_READ_DIFF || fn.acc == disk_status_pkg::PRM_READ_ILK);
	assign acc_stat  = ce && is_status && st_ff.phase == PH_IDLE;
	assign load_now  = ce && st_ff.phase == PH_WAIT && st_ff.cnt == '0;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic lost_set;
		lost_set           = 1'b0;
		nxt_st             = st_ff;
		nxt_st.done_evt    = 1'b0;
		nxt_st.acc_valid   = 1'b0;
		nxt_st.read_start  = 1'b0;
		nxt_st.cmd_valid   = 1'b0;

		// status completion countdown
		if (st_ff.phase == PH_WAIT) begin
			if (st_ff.cnt == '0) begin
				nxt_st.phase       = PH_IDLE;
				nxt_st.busy        = 1'b0;
				nxt_st.done        = 1'b1;
				nxt_st.done_evt    = 1'b1;
				nxt_st.status_word = fmt_word;
			end else begin
				nxt_st.cnt = st_ff.cnt - 1'b1;
			end
		end

		// seek completion gives its own done
		if (drv.seek_done && st_ff.cyl_pend) begin
			nxt_st.cyl_pend = 1'b0;
			nxt_st.done     = 1'b1;
			nxt_st.done_evt = 1'b1;
		end

		// new head group active: launch any stacked read
		if (drv.head_active && st_ff.head_pend) begin
			nxt_st.head_pend = 1'b0;
			if (st_ff.stack_valid) begin
				nxt_st.stack_valid = 1'b0;
				nxt_st.read_start  = 1'b1;
				nxt_st.read_sector = st_ff.stack_arg;
			end
		end

		// function intake
		if (fn.valid) begin
			if (st_ff.phase == PH_WAIT) begin
				lost_set = 1'b1;
			end else if (is_status) begin
				if (nxt_st.stack_valid) begin
					nxt_st.stack_valid = 1'b0;
					lost_set           = 1'b1;
				end
				nxt_st.phase = PH_WAIT;
				nxt_st.cnt   = disk_status_pkg::CNT_W'(disk_status_pkg::STATUS_CYC - 1);
				nxt_st.busy  = 1'b1;
				nxt_st.done  = 1'b0;
				nxt_st.sel   = disk_status_pkg::stat_sel_t'(fn.acc[1:0]);
			end else begin
				unique case (fn.code)
					disk_status_pkg::FN_READ: begin
						if (!nxt_st.head_pend) begin
							nxt_st.read_start  = 1'b1;
							nxt_st.read_sector = fn.acc;
						end else if (nxt_st.stack_valid) begin
							lost_set = 1'b1;
						end else begin
							nxt_st.stack_valid = 1'b1;
							nxt_st.stack_arg   = fn.acc;
						end
					end
					disk_status_pkg::FN_SEL_HEAD: begin
						nxt_st.head_pend = 1'b1;
						nxt_st.cmd_valid = 1'b1;
					end
					disk_status_pkg::FN_SEL_CYL: begin
						nxt_st.cyl_pend  = 1'b1;
						nxt_st.last_pos  = disk_status_pkg::POS_CYL;
						nxt_st.cmd_valid = 1'b1;
					end
					disk_status_pkg::FN_SEL_OFFSET: begin
						nxt_st.last_pos  = disk_status_pkg::POS_OFFSET;
						nxt_st.cmd_valid = 1'b1;
					end
					disk_status_pkg::FN_READ_STATUS: begin
						nxt_st.acc_out   = st_ff.status_word;
						nxt_st.acc_valid = 1'b1;
					end
					default: begin
					end
				endcase
				nxt_st.cmd_code = fn.code;
				nxt_st.cmd_arg  = fn.acc;
			end
		end

		// lost flag: a new event beats a clear in the same cycle
		if (lost_set) begin
			nxt_st.lost_fn = 1'b1;
		end else if (lost_fn_clear) begin
			nxt_st.lost_fn = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_ff             <= '0;
			st_ff.phase       <= PH_IDLE;
			st_ff.sel         <= disk_status_pkg::SEL_CYL;
			st_ff.last_pos    <= disk_status_pkg::POS_NONE;
			st_ff.status_word <= disk_status_pkg::STATUS_RESET;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign busy          = st_ff.busy;
	assign done          = st_ff.done;
	assign done_evt      = st_ff.done_evt;
	assign status_word   = st_ff.status_word;
	assign lost_function = st_ff.lost_fn;
	assign acc_out       = st_ff.acc_out;
	assign acc_valid     = st_ff.acc_valid;
	assign read_start    = st_ff.read_start;
	assign read_sector   = st_ff.read_sector;
	assign drv_cmd_valid = st_ff.cmd_valid;
	assign drv_cmd_code  = st_ff.cmd_code;
	assign drv_cmd_arg   = st_ff.cmd_arg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	busy_on_accept_a: assert property (@(posedge clock) disable iff (sys_rst)
		acc_stat |=> busy && !done)
		else $error("status accept did not raise busy and drop done");

	done_on_load_a: assert property (@(posedge clock) disable iff (sys_rst)
		load_now |=> !busy && done && done_evt)
		else $error("status completion did not flip busy and done");

	word_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		!$past(load_now) && !$past(sys_rst) |-> $stable(status_word))
		else $error("status word changed without a completion");

	cyl_word_a: assert property (@(posedge clock) disable iff (sys_rst)
		load_now && st_ff.sel == disk_status_pkg::SEL_CYL |=> status_word == {6'h00, $past(drv.cyl_sel)})
		else $error("cylinder response wrong");

	head_word_a: assert property (@(posedge clock) disable iff (sys_rst)
		load_now && st_ff.sel == disk_status_pkg::SEL_HEAD && drv.reserved
		|=> status_word[5:4] == 2'b10 && status_word[3:0] == $past(drv.head_grp)
		&& status_word[6] == $past(drv.cap_600) && status_word[15:7] == 9'h000)
		else $error("reserved head response wrong");

	head_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
		load_now && st_ff.sel == disk_status_pkg::SEL_HEAD && !drv.reserved |=> status_word == 16'h0000)
		else $error("unreserved head response not zero");

	diff_word_a: assert property (@(posedge clock) disable iff (sys_rst)
		load_now && st_ff.sel == disk_status_pkg::SEL_DIFF && st_ff.last_pos == disk_status_pkg::POS_CYL
		|=> status_word == {6'h00, ~$past(drv.cyl_to_go)})
		else $error("difference response wrong");

	ilk_word_a: assert property (@(posedge clock) disable iff (sys_rst)
		load_now && st_ff.sel == disk_status_pkg::SEL_ILK
		|=> status_word[5] == 1'b0 && status_word[15:8] == 8'h00 && status_word[7:6] == $past(drv.interlock[7:6]))
		else $error("interlock response wrong");

	displace_a: assert property (@(posedge clock) disable iff (sys_rst)
		acc_stat && st_ff.stack_valid && !(drv.head_active && st_ff.head_pend)
		|=> lost_function && !st_ff.stack_valid && !read_start)
		else $error("stacked read not displaced by status");

	stack_go_a: assert property (@(posedge clock) disable iff (sys_rst)
		ce && drv.head_active && st_ff.head_pend && st_ff.stack_valid
		|=> read_start && read_sector == $past(st_ff.stack_arg))
		else $error("stacked read not launched on head group active");

	read_status_a: assert property (@(posedge clock) disable iff (sys_rst)
		ce && fn.valid && fn.code == disk_status_pkg::FN_READ_STATUS && st_ff.phase == PH_IDLE
		|=> acc_valid && acc_out == $past(status_word))
		else $error("read-status transfer wrong");

endmodule : disk_status_ctrl

`default_nettype wire

// file: drive_unit_model.sv
/*
 * behavioural disk drive unit that answers the channel's forwarded commands:
 * head group select with a delayed activation pulse, cylinder seek with a
 * countdown of cylinders to go, and offset margin selection.
 * assumes one-cycle command pulses and bench-set static drive conditions.
 */
`timescale 1ns/1ns
`default_nettype none

module drive_unit_model (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    sys_rst,
	// commands from the channel
	input  wire logic                    cmd_valid,
	input  wire logic [3:0]              cmd_code,
	input  wire logic [15:0]             cmd_arg,
	// static drive conditions
	input  wire logic                    reserved,
	input  wire logic                    cap_600,
	input  wire logic [7:0]              interlock,
	// status lines to the channel
	output var disk_status_pkg::drive_stat_t drv
);
	logic [9:0] target_ff;
	logic [1:0] step_ff;
	logic [4:0] head_wait_ff;

	// ------------------------------------------------------------
	// drive behaviour
	// ------------------------------------------------------------
	// one cylinder crossed every four cycles; head group active 20 cycles after select
	always_ff @(posedge clock) begin
		drv.head_active <= 1'b0;
		drv.seek_done   <= 1'b0;
		drv.reserved    <= reserved;
		drv.cap_600     <= cap_600;
		drv.interlock   <= interlock;
		if (sys_rst) begin
			drv          <= '0;
			target_ff    <= 10'h000;
			step_ff      <= 2'h0;
			head_wait_ff <= 5'h00;
		end else begin
			if (cmd_valid && cmd_code == disk_status_pkg::FN_SEL_HEAD) begin
				drv.head_grp <= cmd_arg[3:0];
				head_wait_ff <= 5'h14;
			end else if (head_wait_ff != 5'h00) begin
				head_wait_ff    <= head_wait_ff - 5'h01;
				drv.head_active <= (head_wait_ff == 5'h01);
			end
			if (cmd_valid && cmd_code == disk_status_pkg::FN_SEL_CYL) begin
				target_ff     <= cmd_arg[9:0];
				step_ff       <= 2'h0;
				drv.cyl_to_go <= (cmd_arg[9:0] > drv.cyl_sel) ? cmd_arg[9:0] - drv.cyl_sel
					: drv.cyl_sel - cmd_arg[9:0];
			end else if (drv.cyl_to_go != 10'h000) begin
				step_ff <= step_ff + 2'h1;
				if (step_ff == 2'h3) begin
					drv.cyl_to_go <= drv.cyl_to_go - 10'h001;
					if (drv.cyl_to_go == 10'h001) begin
						drv.cyl_sel   <= target_ff;
						drv.seek_done <= 1'b1;
					end
				end
			end
			if (cmd_valid && cmd_code == disk_status_pkg::FN_SEL_OFFSET) begin
				drv.offset_num    <= cmd_arg[4:0];
				drv.offset_inward <= cmd_arg[5];
			end
		end
	end
endmodule : drive_unit_model

`default_nettype wire

// file: disk_channel_drive_status_readback_test.sv
/*
 * self-checking bench for the drive-status interpreter: status requests of
 * every kind, seek overlap, stacking behind a head select and lost functions.
 * assumes the drive unit model and the design's package are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module disk_channel_drive_status_readback_test;
	logic                         clock, sys_rst, ce, lost_fn_clear, reserved, cap_600;
	logic [7:0]                   interlock;
	disk_status_pkg::fn_req_t     fn;
	disk_status_pkg::drive_stat_t drv, snap;
	logic                         busy, done, done_evt, lost_function, acc_valid, read_start, drv_cmd_valid;
	logic [15:0]                  status_word, acc_out, read_sector, drv_cmd_arg, last_exp;
	logic [3:0]                   drv_cmd_code;
	int                           n_errors, n_tests, lp, k, n_reads;

	// ------------------------------------------------------------
	// design and drive unit
	// ------------------------------------------------------------
	disk_status_ctrl uut (.clock(clock), .sys_rst(sys_rst), .ce(ce), .fn(fn), .lost_fn_clear(lost_fn_clear),
		.drv(drv), .busy(busy), .done(done), .done_evt(done_evt), .status_word(status_word),
		.lost_function(lost_function), .acc_out(acc_out), .acc_valid(acc_valid), .read_start(read_start),
		.read_sector(read_sector), .drv_cmd_valid(drv_cmd_valid), .drv_cmd_code(drv_cmd_code),
		.drv_cmd_arg(drv_cmd_arg));
	drive_unit_model drive_model (.clock(clock), .sys_rst(sys_rst), .cmd_valid(drv_cmd_valid),
		.cmd_code(drv_cmd_code), .cmd_arg(drv_cmd_arg), .reserved(reserved), .cap_600(cap_600),
		.interlock(interlock), .drv(drv));

	// clock and read launch counter
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) if (read_start === 1'b1) n_reads++;

	// ------------------------------------------------------------
	// compare, access and wait tasks
	// ------------------------------------------------------------
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic final_report();
		if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report

	// one-cycle request, raised at a falling edge, dropped at the taking edge
	task automatic send(input logic [3:0] code, input logic [15:0] acc);
		fn = '{valid: 1'b1, code: code, acc: acc};
		@(posedge clock);
		fn.valid <= 1'b0;
		@(negedge clock);
	endtask : send

	// bounded wait for done; snap keeps the drive lines of the loading edge
	task automatic wait_done(input int bound, output int cyc);
		cyc = 0;
		while (done_evt !== 1'b1) begin
			if (cyc >= bound) begin
				n_errors++;
				$display("CHECK FAILED done pulse expected 1 seen 0");
				final_report();
			end
			snap = drv;
			@(negedge clock);
			cyc++;
		end
	endtask : wait_done

	// bounded wait: 0 head group active, 1 read launch
	task automatic wait_for(input int which);
		int n;
		n = 0;
		while ((which == 0 ? drv.head_active : read_start) !== 1'b1) begin
			if (n == 100) begin
				n_errors++;
				$display("CHECK FAILED pulse %0d expected 1 seen 0", which);
				final_report();
			end
			@(negedge clock);
			n++;
		end
	endtask : wait_for

	// status request of kind sel (0 cylinder, 1 head, 2 margin/difference, 3 interlock), then read-back
	task automatic status(input logic [1:0] sel, input string what);
		int cyc;
		send(disk_status_pkg::FN_STATUS, disk_status_pkg::PRM_READ_CYL | 16'(sel));
		chk_bit("busy set", 1'b1, busy);
		chk_bit("done cleared", 1'b0, done);
		wait_done(1000, cyc);
		chk_word("status delay", 16'(disk_status_pkg::STATUS_CYC), 16'(cyc));
		chk_bit("busy cleared", 1'b0, busy);
		case (sel)
			2'h0: last_exp = {6'h00, snap.cyl_sel};
			2'h1: last_exp = snap.reserved ? {9'h000, snap.cap_600, 2'h2, snap.head_grp} : 16'h0000;
			2'h2: last_exp = lp == 1 ? {10'h000, snap.offset_inward, ~snap.offset_num}
				: lp == 2 ? {6'h00, ~snap.cyl_to_go} : 16'h0000;
			default: last_exp = {8'h00, snap.interlock & 8'hDF};
		endcase
		chk_word(what, last_exp, status_word);
		send(disk_status_pkg::FN_READ_STATUS, 16'h0000);
		chk_bit("acc valid", 1'b1, acc_valid);
		chk_word("acc word", last_exp, acc_out);
	endtask : status

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		n_errors = 0;
		n_tests = 0;
		n_reads = 0;
		lp = 0;
		sys_rst = 1'b1;
		ce = 1'b1;
		fn = '0;
		lost_fn_clear = 1'b0;
		reserved = 1'b1;
		cap_600 = 1'b0;
		interlock = 8'h00;
		repeat (12) @(negedge clock);
		chk_word("word after reset", disk_status_pkg::STATUS_RESET, status_word);
		sys_rst = 1'b0;
		@(negedge clock);
		// seek with a status right behind it, then its own done
		send(disk_status_pkg::FN_SEL_CYL, 16'd294);
		lp = 2;
		status(2'h2, "seek difference");
		wait_done(5000, k);
		chk_word("held over seek", last_exp, status_word);
		status(2'h2, "on cylinder");
		chk_word("on cylinder value", 16'h03FF, status_word);
		status(2'h0, "cylinder");
		chk_word("cylinder value", 16'd294, status_word);
		// offset toward and away from centre
		for (int i = 0; i < 2; i++) begin
			send(disk_status_pkg::FN_SEL_OFFSET, i == 0 ? 16'h002A : 16'h0003);
			lp = 1;
			status(2'h2, "offset margin");
		end
		// head groups 0 and 9, large drive, not reserved
		for (int i = 0; i < 4; i++) begin
			reserved = (i != 3);
			cap_600 = (i >= 2);
			send(disk_status_pkg::FN_SEL_HEAD, i == 0 ? 16'h0000 : 16'h0009);
			wait_for(0);
			status(2'h1, "head group");
			if (i < 2) chk_word("head range", i == 0 ? 16'h0020 : 16'h0029, status_word);
		end
		// each interlock flag alone, then all of them
		for (int i = 0; i < 9; i++) begin
			interlock = (i == 8) ? 8'hFF : 8'h01 << i;
			status(2'h3, "interlock");
		end
		interlock = 8'h00;
		send(disk_status_pkg::FN_SEL_OFFSET, 16'h0000);
		repeat (3) @(negedge clock);
		chk_word("held word", last_exp, status_word);
		// read stacked behind a head select
		reserved = 1'b1;
		send(disk_status_pkg::FN_SEL_HEAD, 16'h0003);
		@(negedge clock);
		send(disk_status_pkg::FN_READ, 16'h0011);
		chk_bit("read waits", 1'b0, read_start);
		wait_for(1);
		chk_word("read sector", 16'h0011, read_sector);
		chk_bit("no loss", 1'b0, lost_function);
		// status displaces a stacked read
		send(disk_status_pkg::FN_SEL_HEAD, 16'h0002);
		k = n_reads;
		@(negedge clock);
		send(disk_status_pkg::FN_READ, 16'h0012);
		status(2'h3, "displacing status");
		chk_bit("lost after displace", 1'b1, lost_function);
		chk_word("read discarded", 16'(k), 16'(n_reads));
		lost_fn_clear = 1'b1;
		@(negedge clock);
		lost_fn_clear = 1'b0;
		chk_bit("lost cleared", 1'b0, lost_function);
		// function while busy is lost, first request still served
		interlock = 8'h81;
		repeat (3) @(negedge clock);
		send(disk_status_pkg::FN_STATUS, disk_status_pkg::PRM_READ_ILK);
		send(disk_status_pkg::FN_STATUS, disk_status_pkg::PRM_READ_CYL);
		chk_bit("lost while busy", 1'b1, lost_function);
		ce = 1'b0;
		repeat (4) @(negedge clock);
		chk_bit("frozen busy", 1'b1, busy);
		ce = 1'b1;
		wait_done(1000, k);
		chk_word("first served delay", 16'(disk_status_pkg::STATUS_CYC - 1), 16'(k));
		chk_word("first served word", 16'h0081, status_word);
		final_report();
	end
endmodule : disk_channel_drive_status_readback_test

`default_nettype wire
